// File: pesc_pkg.sv
package pesc_pkg;
    // ==========================================================
    // register map (word-aligned byte addresses)
    localparam logic [7:0] PESC_FLAGS_LO_ADDR = 8'h00;
    localparam logic [7:0] PESC_FLAGS_HI_ADDR = 8'h04;
    localparam logic [7:0] PESC_CTRL_LO_ADDR = 8'h08;
    localparam logic [7:0] PESC_CTRL_HI_ADDR = 8'h0C;
    localparam logic [7:0] PESC_STATUS_ADDR = 8'h10;
    localparam logic [7:0] PESC_CLEAR_ADDR = 8'h14;
    localparam logic [7:0] PESC_ENABLE_ADDR = 8'h18;
    // ==========================================================
    // error flag positions
    localparam int PESC_NFLAGS = 7;
    localparam int PESC_WDPE_BIT = 0;
    localparam int PESC_APE_BIT = 1;
    localparam int PESC_RDPE_BIT = 2;
    localparam int PESC_PERR_BIT = 3;
    localparam int PESC_SERR_BIT = 4;
    localparam int PESC_DTO_BIT = 5;
    localparam int PESC_NMI_BIT = 6;
    // enable of flag n is control bit PESC_EN_TOP - n (63 down to 57)
    localparam int PESC_EN_TOP = 63;
    // pci reset control bit in control register, low word
    localparam int PESC_PCIRST_BIT = 0;
    // ==========================================================
    // reset values
    localparam logic [63:0] PESC_CTRL_RST = 64'h0000_0000_0000_0000;
    localparam logic [31:0] PESC_ZERO32 = 32'h0000_0000;
endpackage

// File: pesc_flag.sv
`timescale 1ns/100ps
// one sticky error flag: set wins over clear
module pesc_flag (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic set_i,
    input wire logic clr_i,
    output logic flag_o
);
    logic flag_q;
    logic flag_d;
    // ==========================================================
    // next state
    assign flag_d = set_i ? 1'b1 : (clr_i ? 1'b0 : flag_q);
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end
    assign flag_o = flag_q;
endmodule

// File: pesc_top.sv
`timescale 1ns/100ps
// Overview of operation
// - target write data parity error sets bit 0
// - target address parity error sets bit 1
// - initiator read data parity error sets bit 2
// - perr seen while participating sets bit 3
// - serr seen while initiator sets bit 4
// - control bits 63..57 enable flags 0..6
// - writing one clears flag, zero keeps
// - reset or pci reset control clears flags
// - initiator device timeout sets bit 5
// - nonmaskable interrupt input sets bit 6
// - flag bits 63..7 read zero
module pesc_top
    import pesc_pkg::*;
(
    input wire logic MCLK_I,
    input wire logic RST_I,
    // wishbone classic slave
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [7:0] ADR_I,
    input wire logic [3:0] SEL_I,
    input wire logic [31:0] DAT_I,
    output logic [31:0] DAT_O,
    output logic ACK_O,
    output logic ERR_O,
    // pci error events, one-cycle or level, sampled each clock
    input wire logic TGT_WR_DATA_PERR_I,
    input wire logic TGT_ADDR_PERR_I,
    input wire logic INIT_RD_DATA_PERR_I,
    input wire logic PARTICIPATING_I,
    input wire logic INITIATOR_I,
    input wire logic PERR_N_I,
    input wire logic SERR_N_I,
    input wire logic DEV_TIMEOUT_I,
    input wire logic NMI_I,
    // outputs
    output logic PCI_RESET_O,
    output logic SYS_ERR_INT_O,
    output logic EVT_INT_O
);
    localparam int N = PESC_NFLAGS;

    logic [N-1:0] evt;
    logic [N-1:0] flags;
    logic [N-1:0] flag_en;
    logic [N-1:0] flag_clr;
    logic [63:0] ctrl_q;
    logic [N-1:0] st_q;
    logic [N-1:0] ien_q;
    logic ack_q;
    logic [31:0] dat_q;
    logic req;
    logic wr_stb;
    logic rd_stb;
    logic hit_flo;
    logic hit_fhi;
    logic hit_clo;
    logic hit_chi;
    logic hit_st;
    logic hit_clr;
    logic hit_ien;
    logic mapped;
    logic [31:0] wmask;
    logic [31:0] rd_mux;
    logic pci_rst;

    // ==========================================================
    // error event detection
    assign evt[PESC_WDPE_BIT] = TGT_WR_DATA_PERR_I;
    assign evt[PESC_APE_BIT] = TGT_ADDR_PERR_I;
    assign evt[PESC_RDPE_BIT] = INIT_RD_DATA_PERR_I;
    assign evt[PESC_PERR_BIT] = ~PERR_N_I & PARTICIPATING_I;
    assign evt[PESC_SERR_BIT] = ~SERR_N_I & INITIATOR_I;
    assign evt[PESC_DTO_BIT] = DEV_TIMEOUT_I & INITIATOR_I;
    assign evt[PESC_NMI_BIT] = NMI_I;

    // ==========================================================
    // bus decode
    assign req = CYC_I & STB_I & ~ack_q;
    assign wr_stb = req & WE_I;
    assign rd_stb = req & ~WE_I;
    assign hit_flo = (ADR_I == PESC_FLAGS_LO_ADDR);
    assign hit_fhi = (ADR_I == PESC_FLAGS_HI_ADDR);
    assign hit_clo = (ADR_I == PESC_CTRL_LO_ADDR);
    assign hit_chi = (ADR_I == PESC_CTRL_HI_ADDR);
    assign hit_st = (ADR_I == PESC_STATUS_ADDR);
    assign hit_clr = (ADR_I == PESC_CLEAR_ADDR);
    assign hit_ien = (ADR_I == PESC_ENABLE_ADDR);
    assign mapped = hit_flo | hit_fhi | hit_clo | hit_chi | hit_st | hit_clr | hit_ien;
    assign wmask = {{8{SEL_I[3]}}, {8{SEL_I[2]}}, {8{SEL_I[1]}}, {8{SEL_I[0]}}};

    // ==========================================================
    // flag clearing: write one, or pci reset control
    assign pci_rst = ctrl_q[PESC_PCIRST_BIT];
    assign flag_clr = ({N{wr_stb & hit_flo}} & DAT_I[N-1:0] & wmask[N-1:0])
                      | {N{pci_rst}};

    // ==========================================================
    // sticky flags, one cell each
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_flag
            pesc_flag u_flag (
                .mclk_i(MCLK_I),
                .rst_i(RST_I),
                .set_i(evt[g] & ~pci_rst),
                .clr_i(flag_clr[g]),
                .flag_o(flags[g])
            );
            assign flag_en[g] = ctrl_q[PESC_EN_TOP - g];
        end
    endgenerate

    // ==========================================================
    // hardware error interrupt
    assign SYS_ERR_INT_O = |(flags & flag_en);
    assign PCI_RESET_O = pci_rst;

    // ==========================================================
    // control register
    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            ctrl_q <= PESC_CTRL_RST;
        end else if (wr_stb & hit_clo) begin
            ctrl_q[31:0] <= (ctrl_q[31:0] & ~wmask) | (DAT_I & wmask);
        end else if (wr_stb & hit_chi) begin
            ctrl_q[63:32] <= (ctrl_q[63:32] & ~wmask) | (DAT_I & wmask);
        end
    end

    // ==========================================================
    // event status, clear and enable
    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            st_q <= '0;
        end else begin
            st_q <= evt | (st_q & ~({N{wr_stb & hit_clr}} & DAT_I[N-1:0] & wmask[N-1:0]));
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            ien_q <= '0;
        end else if (wr_stb & hit_ien) begin
            ien_q <= (ien_q & ~wmask[N-1:0]) | (DAT_I[N-1:0] & wmask[N-1:0]);
        end
    end
    assign EVT_INT_O = |(st_q & ien_q);

    // ==========================================================
    // read data mux; upper flag bits read zero
    assign rd_mux = hit_flo ? {{(32-N){1'b0}}, flags} :
                    hit_fhi ? PESC_ZERO32 :
                    hit_clo ? ctrl_q[31:0] :
                    hit_chi ? ctrl_q[63:32] :
                    hit_st ? {{(32-N){1'b0}}, st_q} :
                    hit_ien ? {{(32-N){1'b0}}, ien_q} :
                    PESC_ZERO32;

    // ==========================================================
    // bus answer one cycle after request
    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            ack_q <= 1'b0;
            dat_q <= PESC_ZERO32;
        end else begin
            ack_q <= req;
            if (rd_stb) begin
                dat_q <= rd_mux;
            end
        end
    end
    logic err_q;
    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            err_q <= 1'b0;
        end else begin
            err_q <= req & ~mapped;
        end
    end
    assign ACK_O = ack_q & ~err_q;
    assign ERR_O = err_q;
    assign DAT_O = dat_q;

    // ==========================================================
    // checks
    AST_WDPE: assert property (@(posedge MCLK_I) disable iff (RST_I)
        TGT_WR_DATA_PERR_I & ~pci_rst |=> flags[PESC_WDPE_BIT])
        else $error("write parity flag not set");
    AST_APE: assert property (@(posedge MCLK_I) disable iff (RST_I)
        TGT_ADDR_PERR_I & ~pci_rst |=> flags[PESC_APE_BIT]) else $error("addr parity flag not set");
    AST_RDPE: assert property (@(posedge MCLK_I) disable iff (RST_I)
        INIT_RD_DATA_PERR_I & ~pci_rst |=> flags[PESC_RDPE_BIT]) else $error("read parity flag");
    AST_PERR: assert property (@(posedge MCLK_I) disable iff (RST_I)
        ~PERR_N_I & PARTICIPATING_I & ~pci_rst |=> flags[PESC_PERR_BIT]) else $error("perr flag");
    AST_SERR: assert property (@(posedge MCLK_I) disable iff (RST_I)
        ~SERR_N_I & INITIATOR_I & ~pci_rst |=> flags[PESC_SERR_BIT]) else $error("serr flag");
    AST_INT: assert property (@(posedge MCLK_I) disable iff (RST_I)
        flags[0] & ctrl_q[63] |-> SYS_ERR_INT_O) else $error("interrupt missing");
    AST_W1C: assert property (@(posedge MCLK_I) disable iff (RST_I)
        wr_stb & hit_flo & DAT_I[0] & SEL_I[0] & ~evt[0] |=> ~flags[0]) else $error("w1c fail");
    AST_PRST: assert property (@(posedge MCLK_I) disable iff (RST_I)
        pci_rst |=> flags == '0) else $error("pci reset did not clear");
    AST_DTO: assert property (@(posedge MCLK_I) disable iff (RST_I)
        DEV_TIMEOUT_I & INITIATOR_I & ~pci_rst |=> flags[PESC_DTO_BIT]) else $error("timeout");
    AST_NMI: assert property (@(posedge MCLK_I) disable iff (RST_I)
        NMI_I & ~pci_rst |=> flags[PESC_NMI_BIT]) else $error("nmi flag");
    AST_MBZ: assert property (@(posedge MCLK_I) disable iff (RST_I)
        rd_stb & hit_fhi |=> DAT_O == PESC_ZERO32) else $error("reserved bits nonzero");
    AST_NOINT: assert property (@(posedge MCLK_I) disable iff (RST_I)
        (flags & flag_en) == '0 |-> ~SYS_ERR_INT_O) else $error("spurious interrupt");
    COV_INT: cover property (@(posedge MCLK_I) disable iff (RST_I) $rose(SYS_ERR_INT_O));
    COV_CLR: cover property (@(posedge MCLK_I) disable iff (RST_I) $fell(SYS_ERR_INT_O));
    COV_RACE: cover property (@(posedge MCLK_I) disable iff (RST_I) evt[0] & flag_clr[0]);
endmodule

// File: pesc_pci_agent.sv
`timescale 1ns/100ps
// pci agent model: drives one error event for one cycle on request
module pesc_pci_agent (
    input wire logic mclk_i,
    input wire logic fire_i,
    input wire logic [2:0] kind_i,
    output logic [8:0] pins_o
);
    // pins: {nmi, dto, serr_n, perr_n, init, part, rdpe, ape, wdpe}
    localparam logic [8:0] IDLE = 9'h060;
    logic [8:0] ev_pat;
    // ==========================================================
    // event patterns
    always_comb begin
        case (kind_i)
            3'h0: ev_pat = 9'h069;
            3'h1: ev_pat = 9'h06A;
            3'h2: ev_pat = 9'h07C;
            3'h3: ev_pat = 9'h048; // peer perr_n, bridge taking part
            3'h4: ev_pat = 9'h038; // peer serr_n, bridge initiator
            3'h5: ev_pat = 9'h0F8;
            3'h6: ev_pat = 9'h160;
            default: ev_pat = 9'h000; // both strobes low, bridge idle
        endcase
    end
    // ==========================================================
    // one-cycle event, strobes released high otherwise
    always_ff @(posedge mclk_i) begin
        pins_o <= fire_i ? ev_pat : IDLE;
    end
endmodule

// File: pesc_top_test.sv
`timescale 1ns/100ps
module pesc_top_test;
    import pesc_pkg::*;
    logic MCLK_I = 1'b0;
    logic RST_I, CYC_I, STB_I, WE_I, ACK_O, ERR_O, PCI_RESET_O, SYS_ERR_INT_O, EVT_INT_O;
    logic [7:0] ADR_I;
    logic [3:0] SEL_I;
    logic [31:0] DAT_I, DAT_O, q;
    logic [8:0] pins;
    logic fire, last_err;
    logic [2:0] kind;
    int errors = 0;
    int total_checks = 0;
    int seed;
    // ==========================================================
    // clock, design and far-side agent
    always #2 MCLK_I = ~MCLK_I;
    pesc_top dut (.MCLK_I(MCLK_I), .RST_I(RST_I), .CYC_I(CYC_I), .STB_I(STB_I),
        .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O),
        .ACK_O(ACK_O), .ERR_O(ERR_O), .TGT_WR_DATA_PERR_I(pins[0]),
        .TGT_ADDR_PERR_I(pins[1]), .INIT_RD_DATA_PERR_I(pins[2]),
        .PARTICIPATING_I(pins[3]), .INITIATOR_I(pins[4]), .PERR_N_I(pins[5]),
        .SERR_N_I(pins[6]), .DEV_TIMEOUT_I(pins[7]), .NMI_I(pins[8]),
        .PCI_RESET_O(PCI_RESET_O), .SYS_ERR_INT_O(SYS_ERR_INT_O), .EVT_INT_O(EVT_INT_O));
    pesc_pci_agent agent (.mclk_i(MCLK_I), .fire_i(fire), .kind_i(kind), .pins_o(pins));
    // ==========================================================
    // helpers
    function automatic logic [31:0] en_bit(input int n);
        return 32'h1 << (PESC_EN_TOP - 32 - n);
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    // classic cycle, held until ack or err is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        CYC_I <= 1'b1;
        STB_I <= 1'b1;
        WE_I <= w;
        ADR_I <= a;
        DAT_I <= d;
        // only the watchdog ends a wait that never gets an answer
        do begin
            @(posedge MCLK_I);
        end while (ACK_O !== 1'b1 && ERR_O !== 1'b1);
        q = DAT_O;
        last_err = ERR_O;
        CYC_I <= 1'b0;
        STB_I <= 1'b0;
        @(posedge MCLK_I);
    endtask
    task automatic ev(input logic [2:0] k);
        kind <= k;
        fire <= 1'b1;
        @(posedge MCLK_I);
        fire <= 1'b0;
        repeat (2) @(posedge MCLK_I);
    endtask
    task summarize;
        if (errors == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // ==========================================================
    // watchdog
    initial begin
        repeat (5000) @(posedge MCLK_I);
        errors++;
        summarize();
    end
    // ==========================================================
    // main sequence
    initial begin
        {RST_I, CYC_I, STB_I, WE_I, fire, kind} = 8'h80;
        ADR_I = 8'h00;
        SEL_I = 4'hF;
        DAT_I = 32'h0000_0000;
        seed = $urandom(32'h621a);
        repeat (20) @(posedge MCLK_I);
        RST_I <= 1'b0;
        @(posedge MCLK_I);
        wb(0, PESC_FLAGS_LO_ADDR, 0); chk("flags_rst", 0, q);
        for (int n = 0; n < PESC_NFLAGS; n++) begin
            ev(3'(n));
            wb(0, PESC_FLAGS_LO_ADDR, 0); chk("flag_set", 32'h1 << n, q);
            chk("int_masked", 0, 32'(SYS_ERR_INT_O));
            wb(1, PESC_CTRL_HI_ADDR, en_bit(n)); chk("int_on", 1, 32'(SYS_ERR_INT_O));
            wb(1, PESC_FLAGS_LO_ADDR, $urandom & ~(32'h1 << n));
            wb(0, PESC_FLAGS_LO_ADDR, 0); chk("w0_keep", 32'h1 << n, q);
            wb(1, PESC_FLAGS_LO_ADDR, 32'h1 << n);
            wb(0, PESC_FLAGS_LO_ADDR, 0); chk("w1_clr", 0, q);
            chk("int_off", 0, 32'(SYS_ERR_INT_O));
        end
        ev(3'h7);
        wb(0, PESC_FLAGS_LO_ADDR, 0); chk("unqualified", 0, q);
        wb(1, PESC_FLAGS_HI_ADDR, 32'hFFFF_FFFF);
        wb(0, PESC_FLAGS_HI_ADDR, 0); chk("flags_hi", 0, q);
        ev(3'h3);
        wb(1, PESC_CTRL_LO_ADDR, 32'h1); chk("pci_rst", 1, 32'(PCI_RESET_O));
        ev(3'h6);
        wb(0, PESC_FLAGS_LO_ADDR, 0); chk("rst_clr", 0, q);
        wb(1, PESC_CTRL_LO_ADDR, 0);
        wb(0, 8'h40, 0); chk("unmapped", 1, 32'(last_err));
        wb(1, PESC_ENABLE_ADDR, 0); chk("evt_masked", 0, 32'(EVT_INT_O));
        wb(1, PESC_ENABLE_ADDR, 32'hFFFF_FFFF); chk("evt_on", 1, 32'(EVT_INT_O));
        wb(1, PESC_CLEAR_ADDR, 32'hFFFF_FFFF); chk("evt_clr", 0, 32'(EVT_INT_O));
        wb(0, PESC_STATUS_ADDR, 0); chk("status_clr", 0, q);
        ev(3'h0); chk("evt_again", 1, 32'(EVT_INT_O));
        summarize();
    end
endmodule
